// file: include/byte_shift_if.sv
// carrier between the register block and its serial read-out shifter
`timescale 1ns/100ps
interface byte_shift_if;
  logic       load;
  logic [7:0] data;
  logic       sck_fall;
  logic       bit_out;

  modport ctrl (output load, output data, output sck_fall, input bit_out);
  modport shifter (input load, input data, input sck_fall, output bit_out);
endinterface

// file: include/flash_regs_params.svh
// constants for the flash status and configuration register block
`ifndef FLASH_REGS_PARAMS_SVH
`define FLASH_REGS_PARAMS_SVH

`define ST_BUSY_LO      0
`define ST_WEL          1
`define ST_WSE_BIT      2
`define ST_WSP_BIT      3
`define ST_LOCKDOWN     4
`define ST_SEC_LOCK     5
`define ST_BUSY_HI      7

`define CF_QUAD_EN      1
`define CF_NO_PERM_LOCK 3
`define CF_RST_HOLD     6
`define CF_WP_EN        7

`define CF_WRITE_MASK   8'hc2
`define CF_RESET        8'h08

// self-timed protect-enable write time, in ns
`define HW_WRITE_PROTECT_ENABLE_WRITE_NS   1000
`define MCLK_PERIOD_NS  25

`endif

// file: include/flash_regs_pkg.sv
// types shared by the flash status and configuration block
package flash_regs_pkg;

  typedef enum logic [3:0] {
    cmd_none,
    cmd_write_enable,
    cmd_write_disable,
    cmd_program_start,
    cmd_erase_start,
    cmd_suspend,
    cmd_resume,
    cmd_lockdown_bp,
    cmd_lockout_sid,
    cmd_write_bp,
    cmd_write_config,
    cmd_soft_reset,
    cmd_quad_single_line
  } cmd_kind_type;

  typedef enum logic [1:0] {
    op_idle,
    op_erase,
    op_program,
    op_hw_write_protect_enable_write
  } op_kind_type;

endpackage

// file: rtl/byte_shifter.sv
// shifts a register byte out msb first on serial clock falling edges
`timescale 1ns/100ps
module byte_shifter (
  input wire logic    mclk,
  input wire logic    rst,
  byte_shift_if.shifter sh
);
  logic [7:0] shift_r;

  // shifting rotates the byte so repeated reads stream the same value
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      shift_r <= 8'h00;
    end else if (sh.load) begin
      shift_r <= sh.data;
    end else if (sh.sck_fall) begin
      shift_r <= {shift_r[6:0], shift_r[7]};
    end
  end

  assign sh.bit_out = shift_r[7];
endmodule // byte_shifter

// file: rtl/flash_status_config_regs.sv
// status and configuration registers of the serial flash
`timescale 1ns/100ps
`include "flash_regs_params.svh"
module flash_status_config_regs #(
  parameter int HW_WRITE_PROTECT_ENABLE_WRITE_NS = `HW_WRITE_PROTECT_ENABLE_WRITE_NS
) (
  input  wire logic                        mclk,
  input  wire logic                        rst,
  input  wire logic                        cmd_valid,
  input  wire flash_regs_pkg::cmd_kind_type cmd_kind,
  input  wire logic [7:0]                  cmd_data,
  input  wire logic                        array_done,
  input  wire logic                        four_bit_command_mode,
  input  wire logic                        nonvolatile_lockdown_any,
  input  wire logic                        sec_stored,
  input  wire logic [1:0]                  nv_cfg_stored,
  input  wire logic                        write_protect_pin_n,
  input  wire logic                        sck,
  input  wire logic                        read_start,
  input  wire logic                        read_select_config,
  output logic [7:0]                       status_out,
  output logic [7:0]                       config_out,
  output logic                             pins_are_data,
  output logic                             shared_pin_is_reset,
  output logic                             hw_protected,
  output logic                             cmd_rejected,
  output logic                             nv_cfg_write,
  output logic                             read_bit
);
  localparam int HW_WRITE_PROTECT_ENABLE_CYCLES_RAW = HW_WRITE_PROTECT_ENABLE_WRITE_NS / `MCLK_PERIOD_NS;
  localparam int HW_WRITE_PROTECT_ENABLE_CYCLES = (HW_WRITE_PROTECT_ENABLE_CYCLES_RAW < 1) ? 1 : HW_WRITE_PROTECT_ENABLE_CYCLES_RAW;
  localparam int CNT_W = $clog2(HW_WRITE_PROTECT_ENABLE_CYCLES + 1);

  generate
    if (HW_WRITE_PROTECT_ENABLE_WRITE_NS < 1) begin : g_bad_time
      $error("protect enable write time must be positive");
    end
  endgenerate

  flash_regs_pkg::op_kind_type op_r;
  logic             busy_r;
  logic             wel_r;
  logic             wse_r;
  logic             wsp_r;
  logic             lockdown_r;
  logic             sec_r;
  logic             quad_en_r;
  logic             rst_hold_r;
  logic             wp_en_r;
  logic             loaded_r;
  logic [CNT_W-1:0] hw_write_protect_enable_cnt_r;
  logic [2:0]       wp_sync_r;
  logic [2:0]       sck_sync_r;
  logic             wp_low_r;
  logic             sck_lvl_r;
  logic             hw_prot;
  logic             go;
  logic [7:0]       status_nxt;
  logic [7:0]       config_nxt;
  byte_shift_if     sh ();

  // pins from outside: three stages, a change counts once the last two stages agree
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wp_sync_r  <= 3'h7;
      sck_sync_r <= 3'h0;
      wp_low_r   <= 1'b0;
      sck_lvl_r  <= 1'b0;
    end else begin
      wp_sync_r  <= {wp_sync_r[1:0], write_protect_pin_n};
      sck_sync_r <= {sck_sync_r[1:0], sck};
      if (wp_sync_r[1] == wp_sync_r[2]) begin
        wp_low_r <= ~wp_sync_r[2];
      end
      if (sck_sync_r[1] == sck_sync_r[2]) begin
        sck_lvl_r <= sck_sync_r[2];
      end
    end
  end

  assign hw_prot = wp_low_r & wp_en_r;
  assign go = cmd_valid & loaded_r;

  // non-volatile bits are caught once after reset release
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      loaded_r <= 1'b0;
    end else begin
      loaded_r <= 1'b1;
    end
  end

  // internal operation tracking: busy, suspend flags, timed write
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      op_r       <= flash_regs_pkg::op_idle;
      busy_r     <= 1'b0;
      wse_r      <= 1'b0;
      wsp_r      <= 1'b0;
      hw_write_protect_enable_cnt_r <= '0;
    end else if (go && cmd_kind == flash_regs_pkg::cmd_soft_reset) begin
      op_r   <= flash_regs_pkg::op_idle;
      busy_r <= 1'b0;
      wse_r  <= 1'b0;
      wsp_r  <= 1'b0;
    end else if (busy_r && op_r == flash_regs_pkg::op_hw_write_protect_enable_write) begin
      if (hw_write_protect_enable_cnt_r == CNT_W'(1)) begin
        busy_r <= 1'b0;
        op_r   <= flash_regs_pkg::op_idle;
      end
      hw_write_protect_enable_cnt_r <= hw_write_protect_enable_cnt_r - CNT_W'(1);
    end else if (busy_r && array_done) begin
      busy_r <= 1'b0;
      op_r   <= flash_regs_pkg::op_idle;
    end else if (go) begin
      case (cmd_kind)
        flash_regs_pkg::cmd_erase_start: begin
          if (wel_r && !busy_r) begin
            busy_r <= 1'b1;
            op_r   <= flash_regs_pkg::op_erase;
          end
        end
        flash_regs_pkg::cmd_program_start: begin
          if (wel_r && !busy_r) begin
            busy_r <= 1'b1;
            op_r   <= flash_regs_pkg::op_program;
          end
        end
        flash_regs_pkg::cmd_suspend: begin
          if (busy_r && op_r == flash_regs_pkg::op_erase) begin
            wse_r  <= 1'b1;
            busy_r <= 1'b0;
          end else if (busy_r && op_r == flash_regs_pkg::op_program) begin
            wsp_r  <= 1'b1;
            busy_r <= 1'b0;
          end
        end
        flash_regs_pkg::cmd_resume: begin
          if (wse_r && op_r == flash_regs_pkg::op_erase) begin
            wse_r  <= 1'b0;
            busy_r <= 1'b1;
          end else if (wsp_r && op_r == flash_regs_pkg::op_program) begin
            wsp_r  <= 1'b0;
            busy_r <= 1'b1;
          end
        end
        flash_regs_pkg::cmd_write_config: begin
          // a changed protect enable costs a self-timed write
          if (wel_r && !busy_r && !hw_prot
              && cmd_data[`CF_WP_EN] != wp_en_r) begin
            busy_r     <= 1'b1;
            op_r       <= flash_regs_pkg::op_hw_write_protect_enable_write;
            hw_write_protect_enable_cnt_r <= CNT_W'(HW_WRITE_PROTECT_ENABLE_CYCLES);
          end
        end
        default: begin
        end
      endcase
    end
  end

  // write enable latch
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wel_r <= 1'b0;
    end else if (busy_r && array_done) begin
      wel_r <= 1'b0;
    end else if (go) begin
      case (cmd_kind)
        flash_regs_pkg::cmd_write_enable: wel_r <= !busy_r;
        flash_regs_pkg::cmd_erase_start,
        flash_regs_pkg::cmd_program_start: wel_r <= wel_r & busy_r;
        flash_regs_pkg::cmd_resume,
        flash_regs_pkg::cmd_quad_single_line: wel_r <= wel_r;
        default: wel_r <= 1'b0;
      endcase
    end
  end

  // lock flags: lockdown dies only with power, security lock never
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lockdown_r <= 1'b0;
      sec_r      <= 1'b0;
    end else begin
      if (!loaded_r && sec_stored) begin
        sec_r <= 1'b1;
      end
      if (go && wel_r && !busy_r) begin
        if (cmd_kind == flash_regs_pkg::cmd_lockdown_bp) begin
          lockdown_r <= 1'b1;
        end
        if (cmd_kind == flash_regs_pkg::cmd_lockout_sid) begin
          sec_r <= 1'b1;
        end
      end
    end
  end

  // configuration bits; reserved and indicator bits are never written
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      quad_en_r  <= 1'b0;
      rst_hold_r <= 1'b0;
      wp_en_r    <= 1'b0;
    end else if (!loaded_r) begin
      rst_hold_r <= nv_cfg_stored[0];
      wp_en_r    <= nv_cfg_stored[1];
    end else if (go && cmd_kind == flash_regs_pkg::cmd_soft_reset) begin
      quad_en_r <= 1'b0;
    end else if (go && cmd_kind == flash_regs_pkg::cmd_write_config
                 && wel_r && !busy_r && !hw_prot) begin
      quad_en_r  <= cmd_data[`CF_QUAD_EN];
      rst_hold_r <= cmd_data[`CF_RST_HOLD];
      wp_en_r    <= cmd_data[`CF_WP_EN];
    end
  end

  always_comb begin
    status_nxt = 8'h00;
    status_nxt[`ST_BUSY_LO]  = busy_r;
    status_nxt[`ST_BUSY_HI]  = busy_r;
    status_nxt[`ST_WEL]      = wel_r;
    status_nxt[`ST_WSE_BIT]  = wse_r;
    status_nxt[`ST_WSP_BIT]  = wsp_r;
    status_nxt[`ST_LOCKDOWN] = lockdown_r;
    status_nxt[`ST_SEC_LOCK] = sec_r;
    config_nxt = 8'h00;
    config_nxt[`CF_QUAD_EN]      = quad_en_r;
    config_nxt[`CF_NO_PERM_LOCK] = ~nonvolatile_lockdown_any;
    config_nxt[`CF_RST_HOLD]     = rst_hold_r;
    config_nxt[`CF_WP_EN]        = wp_en_r;
  end

  // registered outputs
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      status_out          <= 8'h00;
      config_out          <= `CF_RESET;
      pins_are_data       <= 1'b0;
      shared_pin_is_reset <= 1'b0;
      hw_protected        <= 1'b0;
      cmd_rejected        <= 1'b0;
      nv_cfg_write        <= 1'b0;
    end else begin
      status_out    <= status_nxt;
      config_out    <= config_nxt;
      // four-bit mode always uses the upper pins as data
      pins_are_data <= four_bit_command_mode | quad_en_r;
      shared_pin_is_reset <= rst_hold_r;
      hw_protected  <= hw_prot;
      cmd_rejected  <= go && (
        (cmd_kind == flash_regs_pkg::cmd_quad_single_line
         && !four_bit_command_mode && !quad_en_r)
        || ((cmd_kind == flash_regs_pkg::cmd_write_config
             || cmd_kind == flash_regs_pkg::cmd_write_bp)
            && hw_prot)
        || (cmd_kind == flash_regs_pkg::cmd_write_bp && lockdown_r));
      nv_cfg_write  <= go && cmd_kind == flash_regs_pkg::cmd_write_config
                       && wel_r && !busy_r && !hw_prot;
    end
  end

  // serial read-out of either register on the link clock's falling edge
  logic sck_prev_r;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sck_prev_r <= 1'b0;
      read_bit   <= 1'b0;
    end else begin
      sck_prev_r <= sck_lvl_r;
      read_bit   <= sh.bit_out;
    end
  end

  assign sh.load     = read_start;
  assign sh.data     = read_select_config ? config_nxt : status_nxt;
  assign sh.sck_fall = sck_prev_r & ~sck_lvl_r;

  byte_shifter u_shift (
    .mclk (mclk),
    .rst  (rst),
    .sh   (sh.shifter)
  );
endmodule // flash_status_config_regs

// file: verification/flash_regs_monitor.sv
// checker for the flash status and configuration register ports
`timescale 1ns/100ps
module flash_regs_monitor #(
  parameter int HW_WRITE_PROTECT_ENABLE_WRITE_NS = 1000
) (
  input wire logic                         mclk,
  input wire logic                         rst,
  input wire logic                         cmd_valid,
  input wire flash_regs_pkg::cmd_kind_type cmd_kind,
  input wire logic [7:0]                   cmd_data,
  input wire logic                         array_done,
  input wire logic                         four_bit_command_mode,
  input wire logic                         nonvolatile_lockdown_any,
  input wire logic                         sec_stored,
  input wire logic [1:0]                   nv_cfg_stored,
  input wire logic                         write_protect_pin_n,
  input wire logic                         sck,
  input wire logic                         read_start,
  input wire logic                         read_select_config,
  input wire logic [7:0]                   status_out,
  input wire logic [7:0]                   config_out,
  input wire logic                         pins_are_data,
  input wire logic                         shared_pin_is_reset,
  input wire logic                         hw_protected,
  input wire logic                         cmd_rejected,
  input wire logic                         nv_cfg_write,
  input wire logic                         read_bit
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_busy_twin: assert property (status_out[0] == status_out[7])
    else $error("busy copies differ");
  a_reserved_zero: assert property ((config_out & 8'h35) == 8'h00)
    else $error("reserved config bit set");
  a_perm_lock:
    assert property ($stable(nonvolatile_lockdown_any) [*5]
      |-> config_out[3] != nonvolatile_lockdown_any)
    else $error("lock indicator wrong");
  a_pin_roles:
    assert property ((!four_bit_command_mode && $stable(config_out[1])) [*3]
      |-> pins_are_data == config_out[1]) else $error("pin role wrong");
  a_quad_ignored:
    assert property (four_bit_command_mode [*3] |-> pins_are_data)
    else $error("pins not data in four-bit mode");
  a_reset_pin:
    assert property ($stable(config_out[6]) [*3]
      |-> shared_pin_is_reset == config_out[6]) else $error("shared pin wrong");
  a_sec_sticky: assert property (status_out[5] |=> status_out[5])
    else $error("security lock cleared");
  a_quad_gate:
    assert property (cmd_valid && !four_bit_command_mode
      && cmd_kind == flash_regs_pkg::cmd_quad_single_line
      |=> cmd_rejected == !config_out[1])
    else $error("quad command gating wrong");
  a_hw_write_protect_enable_busy:
    assert property (cmd_valid && cmd_kind == flash_regs_pkg::cmd_write_config
      && cmd_data[7] && !config_out[7] && status_out[1] && !status_out[0]
      && !hw_protected |-> ##2 status_out[0]) else $error("no busy on write");
  a_prot_off:
    assert property ((write_protect_pin_n || !config_out[7]) [*6]
      |-> !hw_protected) else $error("protected without cause");
  a_protect_reject:
    assert property (cmd_valid && hw_protected
      && cmd_kind == flash_regs_pkg::cmd_write_config |=> cmd_rejected)
    else $error("protected write accepted");
endmodule // flash_regs_monitor

bind flash_status_config_regs flash_regs_monitor #(
  .HW_WRITE_PROTECT_ENABLE_WRITE_NS(HW_WRITE_PROTECT_ENABLE_WRITE_NS)
) u_flash_regs_monitor (.*);

// file: verification/flash_status_config_regs_bench.sv
// self-checking bench for the flash status and configuration registers
`timescale 1ns/100ps
module flash_status_config_regs_bench;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic array_done = 1'b0;
  logic four_bit_command_mode = 1'b0;
  logic nonvolatile_lockdown_any = 1'b0;
  logic sec_stored = 1'b0;
  logic write_protect_pin_n = 1'b1;
  logic read_start = 1'b0;
  logic read_select_config = 1'b0;
  logic [1:0] nv_cfg_stored = 2'h0;
  logic [7:0] cmd_data = 8'h00;
  flash_regs_pkg::cmd_kind_type cmd_kind = flash_regs_pkg::cmd_none;
  logic [7:0] status_out, config_out, rb;
  logic pins_are_data, shared_pin_is_reset, hw_protected, cmd_rejected;
  logic nv_cfg_write, read_bit, sck, rej, nvw;
  int miscompares = 0;
  int n_checks = 0;

  always #12.5 mclk = ~mclk;
  // short self-timed write keeps the run brief: 10 cycles
  flash_status_config_regs #(.HW_WRITE_PROTECT_ENABLE_WRITE_NS(250)) u_flash_status_config_regs (.*);
  serial_host_reader u_serial_host_reader (.read_bit(read_bit), .sck(sck));

  task automatic chk(input logic [7:0] seen, exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cmd(input flash_regs_pkg::cmd_kind_type k, logic [7:0] d);
    @(negedge mclk);
    cmd_valid = 1'b1;
    cmd_kind = k;
    cmd_data = d;
    @(negedge mclk);
    cmd_valid = 1'b0;
    // refusal and store pulses stand only for the cycle after the take edge
    rej = cmd_rejected;
    nvw = nv_cfg_write;
    repeat (3) begin
      @(negedge mclk);
      rej |= cmd_rejected;
      nvw |= nv_cfg_write;
    end
  endtask
  task automatic wcmd(input flash_regs_pkg::cmd_kind_type k, logic [7:0] d);
    cmd(flash_regs_pkg::cmd_write_enable, 8'h00);
    cmd(k, d);
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    while (status_out[0] !== 1'b0 && n < 400) begin
      @(negedge mclk);
      n++;
    end
    chk({7'h00, status_out[0]}, 8'h00, "busy end");
  endtask
  task automatic read_reg(input logic sel, int half);
    @(negedge mclk);
    read_select_config = sel;
    read_start = 1'b1;
    @(negedge mclk);
    read_start = 1'b0;
    repeat (2) @(negedge mclk);
    u_serial_host_reader.read_byte(half, rb);
  endtask
  task automatic complete_run;
    if (miscompares == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    #400000;
    miscompares++;
    complete_run;
  end

  initial begin
    repeat (6) @(negedge mclk);
    rst = 1'b0;
    repeat (4) @(negedge mclk);
    chk(status_out, 8'h00, "status reset");
    chk(config_out, 8'h08, "config reset");
    cmd(flash_regs_pkg::cmd_quad_single_line, 8'h00);
    chk({7'h00, rej}, 8'h01, "quad refused");
    wcmd(flash_regs_pkg::cmd_write_config, 8'h02);
    wait_idle;
    chk(config_out, 8'h0a, "quad on");
    chk({7'h00, pins_are_data}, 8'h01, "data pins");
    cmd(flash_regs_pkg::cmd_quad_single_line, 8'h00);
    chk({7'h00, rej}, 8'h00, "quad taken");
    four_bit_command_mode = 1'b1;
    wcmd(flash_regs_pkg::cmd_write_config, 8'h00);
    cmd(flash_regs_pkg::cmd_quad_single_line, 8'h00);
    chk({7'h00, rej}, 8'h00, "quad in four-bit");
    chk({7'h00, pins_are_data}, 8'h01, "four-bit pins");
    four_bit_command_mode = 1'b0;
    for (int i = 0; i < 2; i++) begin
      wcmd(i ? flash_regs_pkg::cmd_program_start
             : flash_regs_pkg::cmd_erase_start, 8'h00);
      chk(status_out & 8'h8d, 8'h81, "busy run");
      cmd(flash_regs_pkg::cmd_suspend, 8'h00);
      chk(status_out & 8'h8d, i ? 8'h08 : 8'h04, "paused");
      cmd(flash_regs_pkg::cmd_resume, 8'h00);
      chk(status_out & 8'h8d, 8'h81, "resumed");
      @(negedge mclk) array_done = 1'b1;
      @(negedge mclk) array_done = 1'b0;
      repeat (3) @(negedge mclk);
      chk(status_out & 8'h8d, 8'h00, "op done");
    end
    wcmd(flash_regs_pkg::cmd_write_config, 8'hff);
    chk({7'h00, nvw}, 8'h01, "nv store");
    chk(status_out & 8'h81, 8'h81, "hw_write_protect_enable busy");
    wait_idle;
    chk(config_out, 8'hca, "config mask");
    chk({7'h00, shared_pin_is_reset}, 8'h01, "reset pin");
    write_protect_pin_n = 1'b0;
    repeat (6) @(negedge mclk);
    chk({7'h00, hw_protected}, 8'h01, "protected");
    wcmd(flash_regs_pkg::cmd_write_config, 8'h00);
    chk({7'h00, rej}, 8'h01, "write blocked");
    wcmd(flash_regs_pkg::cmd_lockdown_bp, 8'h00);
    wcmd(flash_regs_pkg::cmd_lockout_sid, 8'h00);
    chk(status_out & 8'h30, 8'h30, "locks set");
    write_protect_pin_n = 1'b1;
    repeat (6) @(negedge mclk);
    chk({7'h00, hw_protected}, 8'h00, "unprotected");
    wcmd(flash_regs_pkg::cmd_write_config, 8'h00);
    wait_idle;
    chk(config_out, 8'h08, "config cleared");
    cmd(flash_regs_pkg::cmd_soft_reset, 8'h00);
    chk(status_out, 8'h30, "soft reset");
    read_reg(1'b1, 100);
    chk(rb, 8'h08, "config read");
    read_reg(1'b0, 100);
    chk(rb, 8'h30, "status read");
    nonvolatile_lockdown_any = 1'b1;
    repeat (6) @(negedge mclk);
    chk(config_out, 8'h00, "perm lock");
    sec_stored = 1'b1;
    nv_cfg_stored = 2'h1;
    rst = 1'b1;
    repeat (6) @(negedge mclk);
    rst = 1'b0;
    repeat (4) @(negedge mclk);
    chk(status_out, 8'h20, "power status");
    chk(config_out, 8'h40, "power config");
    complete_run;
  end
endmodule // flash_status_config_regs_bench

// file: verification/serial_host_reader.sv
// host side reader that clocks one register byte out over the link
`timescale 1ns/100ps
module serial_host_reader (
  input  wire logic read_bit,
  output logic      sck
);
  // link clock stands low between frames
  initial sck = 1'b0;
  task automatic read_byte(input int half, output logic [7:0] b);
    // the block needs a few clocks to see a fall, so each bit is taken
    // at the end of the high phase, a full period after the last fall
    for (int i = 7; i >= 0; i--) begin
      #(half) sck = 1'b1;
      #(half) b[i] = read_bit;
      sck = 1'b0;
    end
    #300;
  endtask
endmodule // serial_host_reader
